// ===== logic/ops_consts.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
// Assumes a 250 MHz system clock and 8-bit APB byte addresses.
`ifndef OPS_CONSTS_SVH
`define OPS_CONSTS_SVH
// Register byte addresses.
`define OPS_ADDR_CTRL 8'h00
`define OPS_ADDR_OVTHR 8'h04
`define OPS_ADDR_OCTHR 8'h08
`define OPS_ADDR_OPTHR 8'h0c
`define OPS_ADDR_STATUS 8'h10
`define OPS_ADDR_ACK 8'h14
`define OPS_ADDR_COUNT 8'h18
// Control register fields.
`define OPS_CTRL_ON 0
`define OPS_CTRL_RESTART_OT 1
`define OPS_CTRL_RESTORE 2
`define OPS_CTRL_RESUME_ML 3
`define OPS_CTRL_LOCAL 4
`define OPS_CTRL_MS 5
`define OPS_CTRL_RST 5'h00
// Status register fields above the alarm bits.
`define OPS_ST_DC_ON 8
`define OPS_ST_MENU 9
`define OPS_ST_READY 10
`define OPS_ST_REMOTE 11
// Alarm bit positions.
`define OPS_NALARM 7
`define OPS_AL_OT 0
`define OPS_AL_OV 1
`define OPS_AL_OC 2
`define OPS_AL_OP 3
`define OPS_AL_FOV 4
`define OPS_AL_SF 5
`define OPS_AL_ML 6
`define OPS_TRIP_MASK 7'h3e
// Limits and times.
`define OPS_OV_MAX_PCT 110
`define OPS_FIXED_OV_MV 60600
`define OPS_CLK_MHZ 250
`define OPS_BOOT_US 10
`define OPS_BOOT_CYC (`OPS_BOOT_US * `OPS_CLK_MHZ)
`define OPS_SHUTDOWN_S 30
`define OPS_SHUTDOWN_CYC (64'd`OPS_SHUTDOWN_S * 64'd`OPS_CLK_MHZ * 64'd1000000)
`endif

// ===== logic/ops_pkg.sv
// Types shared by the supervisor modules.
// Assumes the constants header is compiled alongside.
package ops_pkg;
  // Power sequence of the unit.
  typedef enum logic [1:0] {OPS_BOOT, OPS_RUN, OPS_SHUT, OPS_OFF} ops_state_e;
  // One bit per alarm.
  typedef logic [6:0] ops_alarm_t;
endpackage

// ===== logic/ops_cmp.sv
// Limit comparators for voltage, current and power.
// Assumes measured values are unsigned magnitudes synchronous to clk.
`timescale 1ns/1ns
`include "ops_consts.svh"
module ops_cmp #(
  parameter int VW = 16,
  parameter logic [VW-1:0] FIX_LIM = 16'd6060,
  parameter bit HAS_FIX = 1'b1
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [VW-1:0] volt,
  input wire logic [VW-1:0] curr,
  input wire logic [VW-1:0] ov_thr,
  input wire logic [VW-1:0] oc_thr,
  input wire logic [2*VW-1:0] op_thr,
  output logic ov_hit_ff,
  output logic oc_hit_ff,
  output logic op_hit_ff,
  output logic fov_hit_ff
);
  logic [2*VW-1:0] power; // Product of voltage and current.
  logic nxt_ov_hit;
  logic nxt_oc_hit;
  logic nxt_op_hit;
  logic nxt_fov_hit;

  // Compares each measurement with its limit.
  always_comb begin
    power = volt * curr;
    nxt_ov_hit = volt > ov_thr;
    nxt_oc_hit = curr >= oc_thr;
    nxt_op_hit = power >= op_thr;
    nxt_fov_hit = HAS_FIX && (volt >= FIX_LIM);
  end

  // Registers the comparison results.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ov_hit_ff <= 1'b0;
      oc_hit_ff <= 1'b0;
      op_hit_ff <= 1'b0;
      fov_hit_ff <= 1'b0;
    end else begin
      ov_hit_ff <= nxt_ov_hit;
      oc_hit_ff <= nxt_oc_hit;
      op_hit_ff <= nxt_op_hit;
      fov_hit_ff <= nxt_fov_hit;
    end
  end
endmodule

// ===== logic/ops_flag.sv
// One sticky alarm flag with a guarded clear.
// Assumes set and clear are one-cycle or level terms from the same clock.
`timescale 1ns/1ns
module ops_flag (
  input wire logic clk,
  input wire logic nrst,
  input wire logic set,
  input wire logic clr,
  output logic flag_ff
);
  logic nxt_flag; // Next flag value.

  // A set in the clearing cycle wins.
  always_comb begin
    nxt_flag = flag_ff;
    if (set) begin
      nxt_flag = 1'b1;
    end else if (clr) begin
      nxt_flag = 1'b0;
    end
  end

  // Holds the flag.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // The flag holds from detection until cleared.
  property p_flag_hold;
    @(posedge clk) disable iff (!nrst) (set || (flag_ff && !clr)) |=> flag_ff;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("alarm flag lost");
endmodule

// ===== logic/ops_supervisor.sv
// Output protection and alarm supervisor with an APB register slave.
// Assumes synchronous measurement and status inputs and an NV store outside.
// Function
// - Overheat disables stage; optional auto restart.
// - Overheat flag stays, clearable once overheat is gone.
// - Voltage above settable threshold trips output.
// - Current at limit trips, both directions.
// - Power product at limit trips output.
// - Fixed overvoltage only on 60 V variant.
// - Fixed 60.6 V limit trips output.
// - Fixed overvoltage clears only by power cycle.
// - Share bus misuse or short trips output.
// - Share fault latched until acknowledged after cause.
// - Power-up output state from restore bit and NV store.
// - Switch-off stores state, mains alarm, shutdown.
// - Menu only while output off.
// - Remote takeover unless local mode.
// - Mains loss disables; resume is configurable.
// - Alarms readable, signalled, counted.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "ops_consts.svh"
module ops_supervisor #(
  parameter int VW = 16,
  parameter logic [VW-1:0] NOM_VOLT = 16'd6000,
  parameter int VOLT_LSB_MV = 10,
  parameter bit IS_60V = 1'b1,
  parameter logic [32:0] SHUTDOWN_CYC = 33'(`OPS_SHUTDOWN_CYC)
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [VW-1:0] meas_volt,
  input wire logic [VW-1:0] meas_curr,
  input wire logic overheat,
  input wire logic share_bus_wired,
  input wire logic share_bus_short,
  input wire logic mains_ok,
  input wire logic power_switch_off,
  input wire logic remote_takeover,
  input wire logic remote_release,
  input wire logic nv_saved_on,
  output logic dc_enable,
  output ops_pkg::ops_alarm_t alarm_flags,
  output logic menu_access,
  output logic ready,
  output logic remote_active,
  output logic nv_store,
  output logic nv_store_on,
  output logic shutdown_done
);
  import ops_pkg::*;

  // Fixed limit and the ceiling of the adjustable overvoltage threshold.
  localparam logic [VW-1:0] FIX_LIM = VW'(`OPS_FIXED_OV_MV / VOLT_LSB_MV);
  localparam logic [VW-1:0] OV_MAX = VW'((32'(NOM_VOLT) * `OPS_OV_MAX_PCT) / 100);
  localparam logic [32:0] BOOT_LAST = 33'(`OPS_BOOT_CYC - 1);

  // Tells whether an address holds a register.
  function automatic logic ops_mapped(input logic [7:0] a);
    ops_mapped = (a == `OPS_ADDR_CTRL) || (a == `OPS_ADDR_OVTHR) ||
                 (a == `OPS_ADDR_OCTHR) || (a == `OPS_ADDR_OPTHR) ||
                 (a == `OPS_ADDR_STATUS) || (a == `OPS_ADDR_ACK) ||
                 (a == `OPS_ADDR_COUNT);
  endfunction

  ops_state_e state_ff; // Power sequence state.
  ops_state_e nxt_state;
  logic [32:0] cnt_ff; // Boot and shutdown timer.
  logic [32:0] nxt_cnt;
  logic [5:1] ctrl_ff; // Configuration bits of the control register.
  logic [5:1] nxt_ctrl;
  logic [VW-1:0] ov_thr_ff; // Adjustable thresholds.
  logic [VW-1:0] nxt_ov_thr;
  logic [VW-1:0] oc_thr_ff;
  logic [VW-1:0] nxt_oc_thr;
  logic [2*VW-1:0] op_thr_ff;
  logic [2*VW-1:0] nxt_op_thr;
  logic dc_on_ff; // Commanded output state.
  logic nxt_dc_on;
  logic dc_en_ff; // Power stage enable.
  logic nxt_dc_en;
  logic [15:0] al_cnt_ff; // Alarm counter.
  logic [15:0] nxt_al_cnt;
  logic remote_ff; // Remote control owns the unit.
  logic nxt_remote;
  logic nv_store_ff; // Store strobe and the stored output state.
  logic nxt_nv_store;
  logic nv_on_ff;
  logic nxt_nv_on;
  logic [31:0] prdata_ff; // Read data, loaded in the setup phase.
  logic [31:0] nxt_prdata;
  logic ov_hit; // Comparator results.
  logic oc_hit;
  logic op_hit;
  logic fov_hit;
  logic sf_cause; // Share bus fault cause.
  logic wr_en; // Write strobe of the access phase.
  logic [6:0] ack; // Acknowledge requests written by software.
  logic [6:0] al_set; // Alarm causes this cycle.
  logic [6:0] al_clr; // Allowed clears this cycle.
  logic [6:0] flags; // Latched alarms.
  logic trip; // Any tripping alarm or raw trip cause.

  // Limit comparators.
  ops_cmp #(.VW(VW), .FIX_LIM(FIX_LIM), .HAS_FIX(IS_60V)) u_cmp (
    .clk(clk),
    .nrst(nrst),
    .volt(meas_volt),
    .curr(meas_curr),
    .ov_thr(ov_thr_ff),
    .oc_thr(oc_thr_ff),
    .op_thr(op_thr_ff),
    .ov_hit_ff(ov_hit),
    .oc_hit_ff(oc_hit),
    .op_hit_ff(op_hit),
    .fov_hit_ff(fov_hit)
  );

  // Alarm causes, acknowledges and clearing conditions.
  always_comb begin
    wr_en = psel && penable && pwrite && ops_mapped(paddr);
    ack = (wr_en && paddr == `OPS_ADDR_ACK) ? pwdata[6:0] : 7'h00;
    sf_cause = (share_bus_wired && !ctrl_ff[`OPS_CTRL_MS]) || share_bus_short;
    al_set = 7'h00;
    al_set[`OPS_AL_OT] = overheat;
    al_set[`OPS_AL_OV] = ov_hit;
    al_set[`OPS_AL_OC] = oc_hit;
    al_set[`OPS_AL_OP] = op_hit;
    al_set[`OPS_AL_FOV] = fov_hit;
    al_set[`OPS_AL_SF] = sf_cause;
    al_set[`OPS_AL_ML] = !mains_ok || power_switch_off;
    al_clr = 7'h00;
    al_clr[`OPS_AL_OT] = ack[`OPS_AL_OT];
    al_clr[`OPS_AL_OV] = ack[`OPS_AL_OV] && !ov_hit;
    al_clr[`OPS_AL_OC] = ack[`OPS_AL_OC] && !oc_hit;
    al_clr[`OPS_AL_OP] = ack[`OPS_AL_OP] && !op_hit;
    al_clr[`OPS_AL_FOV] = 1'b0;
    al_clr[`OPS_AL_SF] = ack[`OPS_AL_SF] && !sf_cause;
    al_clr[`OPS_AL_ML] = ack[`OPS_AL_ML] && mains_ok && !power_switch_off;
    trip = |((flags | al_set) & `OPS_TRIP_MASK) || overheat || !mains_ok;
  end

  // One sticky flag per alarm.
  generate
    for (genvar g = 0; g < `OPS_NALARM; g++) begin : g_flag
      ops_flag u_flag (
        .clk(clk),
        .nrst(nrst),
        .set(al_set[g]),
        .clr(al_clr[g]),
        .flag_ff(flags[g])
      );
    end
  endgenerate

  // Power sequence: boot, run, timed shutdown, off.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 33'd1;
    case (state_ff)
      OPS_BOOT: begin
        if (cnt_ff == BOOT_LAST) begin
          nxt_state = OPS_RUN;
          nxt_cnt = 33'd0;
        end
      end
      OPS_RUN: begin
        nxt_cnt = 33'd0;
        if (power_switch_off) begin
          nxt_state = OPS_SHUT;
        end
      end
      OPS_SHUT: begin
        if (cnt_ff == SHUTDOWN_CYC - 33'd1) begin
          nxt_state = OPS_OFF;
        end
      end
      OPS_OFF: begin
        nxt_cnt = cnt_ff;
      end
      default: begin
        nxt_state = OPS_BOOT;
        nxt_cnt = 33'd0;
      end
    endcase
  end

  // Registers the power sequence.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= OPS_BOOT;
      cnt_ff <= 33'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Output command, configuration, thresholds and the stage enable.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ov_thr = ov_thr_ff;
    nxt_oc_thr = oc_thr_ff;
    nxt_op_thr = op_thr_ff;
    nxt_dc_on = dc_on_ff;
    if (wr_en && paddr == `OPS_ADDR_CTRL) begin
      nxt_ctrl = pwdata[5:1];
      // Switching on is refused while a trip is pending.
      if (state_ff == OPS_RUN && !(pwdata[`OPS_CTRL_ON] && trip)) begin
        nxt_dc_on = pwdata[`OPS_CTRL_ON];
      end
    end
    if (wr_en && paddr == `OPS_ADDR_OVTHR) begin
      // Threshold is clamped to its ceiling.
      nxt_ov_thr = (pwdata[VW-1:0] > OV_MAX) ? OV_MAX : pwdata[VW-1:0];
    end
    if (wr_en && paddr == `OPS_ADDR_OCTHR) begin
      nxt_oc_thr = pwdata[VW-1:0];
    end
    if (wr_en && paddr == `OPS_ADDR_OPTHR) begin
      nxt_op_thr = pwdata[2*VW-1:0];
    end
    if (overheat && !ctrl_ff[`OPS_CTRL_RESTART_OT]) begin
      nxt_dc_on = 1'b0;
    end
    if (!mains_ok && !ctrl_ff[`OPS_CTRL_RESUME_ML]) begin
      nxt_dc_on = 1'b0;
    end
    if (|(al_set & `OPS_TRIP_MASK)) begin
      nxt_dc_on = 1'b0;
    end
    if (state_ff != OPS_RUN) begin
      nxt_dc_on = dc_on_ff; // Shutdown keeps the stored state.
    end
    // The power-up state comes last, so the hold above cannot mask it.
    if (state_ff == OPS_BOOT && cnt_ff == BOOT_LAST) begin
      nxt_dc_on = ctrl_ff[`OPS_CTRL_RESTORE] && nv_saved_on;
    end
    nxt_dc_en = dc_on_ff && !trip && state_ff == OPS_RUN && !power_switch_off;
  end

  // Registers the command and configuration.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= `OPS_CTRL_RST;
      ov_thr_ff <= OV_MAX;
      oc_thr_ff <= '1;
      op_thr_ff <= '1;
      dc_on_ff <= 1'b0;
      dc_en_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ov_thr_ff <= nxt_ov_thr;
      oc_thr_ff <= nxt_oc_thr;
      op_thr_ff <= nxt_op_thr;
      dc_on_ff <= nxt_dc_on;
      dc_en_ff <= nxt_dc_en;
    end
  end

  // Alarm counter, remote ownership, store strobe and read data.
  always_comb begin
    nxt_al_cnt = al_cnt_ff + 16'($countones(al_set & ~flags));
    nxt_remote = remote_ff;
    if (remote_release || ctrl_ff[`OPS_CTRL_LOCAL]) begin
      nxt_remote = 1'b0;
    end
    if (remote_takeover && !ctrl_ff[`OPS_CTRL_LOCAL]) begin
      nxt_remote = 1'b1;
    end
    nxt_nv_store = state_ff == OPS_RUN && power_switch_off;
    nxt_nv_on = nxt_nv_store ? dc_on_ff : nv_on_ff;
    nxt_prdata = prdata_ff;
    if (psel && !penable && !pwrite) begin
      nxt_prdata = 32'h0;
      case (paddr)
        `OPS_ADDR_CTRL: nxt_prdata[5:0] = {ctrl_ff, dc_on_ff};
        `OPS_ADDR_OVTHR: nxt_prdata[VW-1:0] = ov_thr_ff;
        `OPS_ADDR_OCTHR: nxt_prdata[VW-1:0] = oc_thr_ff;
        `OPS_ADDR_OPTHR: nxt_prdata[2*VW-1:0] = op_thr_ff;
        `OPS_ADDR_STATUS: begin
          nxt_prdata[6:0] = flags;
          nxt_prdata[`OPS_ST_DC_ON] = dc_en_ff;
          nxt_prdata[`OPS_ST_MENU] = !dc_en_ff;
          nxt_prdata[`OPS_ST_READY] = state_ff == OPS_RUN;
          nxt_prdata[`OPS_ST_REMOTE] = remote_ff;
        end
        `OPS_ADDR_COUNT: nxt_prdata[15:0] = al_cnt_ff;
        default: nxt_prdata = 32'h0;
      endcase
    end
  end

  // Registers the counter, ownership, strobe and read data.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      al_cnt_ff <= 16'h0;
      remote_ff <= 1'b0;
      nv_store_ff <= 1'b0;
      nv_on_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      al_cnt_ff <= nxt_al_cnt;
      remote_ff <= nxt_remote;
      nv_store_ff <= nxt_nv_store;
      nv_on_ff <= nxt_nv_on;
      prdata_ff <= nxt_prdata;
    end
  end

  // Port drive; the slave answers in every access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !ops_mapped(paddr);
  assign prdata = prdata_ff;
  assign dc_enable = dc_en_ff;
  assign alarm_flags = flags;
  assign menu_access = !dc_en_ff;
  assign ready = state_ff == OPS_RUN;
  assign remote_active = remote_ff;
  assign nv_store = nv_store_ff;
  assign nv_store_on = nv_on_ff;
  assign shutdown_done = state_ff == OPS_OFF;

  // Overheat takes the stage down on the next edge.
  property p_ot_off;
    @(posedge clk) disable iff (!nrst) overheat |=> !dc_enable;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("stage on in overheat");

  // Without restart the command is dropped.
  property p_ot_norestart;
    @(posedge clk) disable iff (!nrst)
      (overheat && !ctrl_ff[`OPS_CTRL_RESTART_OT] && state_ff == OPS_RUN) |=> !dc_on_ff;
  endproperty
  a_ot_norestart: assert property (p_ot_norestart) else $error("auto restart");

  // Overheat notice persists until acknowledged.
  property p_ot_keep;
    @(posedge clk) disable iff (!nrst)
      (alarm_flags[`OPS_AL_OT] && !ack[`OPS_AL_OT]) |=> alarm_flags[`OPS_AL_OT];
  endproperty
  a_ot_keep: assert property (p_ot_keep) else $error("overheat notice lost");

  // Overvoltage is flagged two edges after the crossing.
  property p_ov;
    @(posedge clk) disable iff (!nrst)
      (meas_volt > ov_thr_ff && $stable(ov_thr_ff)) |-> ##2 alarm_flags[`OPS_AL_OV];
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage missed");

  // Overcurrent is flagged two edges after the limit is reached.
  property p_oc;
    @(posedge clk) disable iff (!nrst)
      (meas_curr >= oc_thr_ff && $stable(oc_thr_ff)) |-> ##2 alarm_flags[`OPS_AL_OC];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent missed");

  // The fixed limit is never cleared while powered.
  property p_fov_stuck;
    @(posedge clk) disable iff (!nrst)
      alarm_flags[`OPS_AL_FOV] |-> ##1 alarm_flags[`OPS_AL_FOV] ##1 alarm_flags[`OPS_AL_FOV];
  endproperty
  a_fov_stuck: assert property (p_fov_stuck) else $error("fixed alarm cleared");

  // Share fault stays while its cause stands.
  property p_sf_hold;
    @(posedge clk) disable iff (!nrst) (alarm_flags[`OPS_AL_SF] && sf_cause) |=> alarm_flags[`OPS_AL_SF];
  endproperty
  a_sf_hold: assert property (p_sf_hold) else $error("share fault cleared early");

  // Switch-off stores the state, raises the mains alarm, drops the stage.
  property p_switch_off;
    @(posedge clk) disable iff (!nrst)
      (state_ff == OPS_RUN && power_switch_off) |=>
        (nv_store && nv_store_on == $past(dc_on_ff) && !dc_enable && alarm_flags[`OPS_AL_ML]);
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("switch-off not handled");

  // The menu is closed whenever the stage is on.
  property p_menu;
    @(posedge clk) disable iff (!nrst) dc_enable |-> !menu_access;
  endproperty
  a_menu: assert property (p_menu) else $error("menu open while on");

  // Any tripping flag keeps the stage off.
  property p_trip;
    @(posedge clk) disable iff (!nrst) |(alarm_flags & `OPS_TRIP_MASK) |=> !dc_enable;
  endproperty
  a_trip: assert property (p_trip) else $error("stage on with alarm");
endmodule

// ===== tb/ops_plant.sv
// Far-side model: power stage, load and remote controller view.
// Assumes the bench sets source levels and an optional external source.
`timescale 1ns/1ns
module ops_plant (
  input wire logic dc_enable,
  input wire logic ext_on,
  input wire logic [15:0] ext_volt,
  input wire logic [15:0] set_volt,
  input wire logic [15:0] set_curr,
  input wire logic ready,
  input wire ops_pkg::ops_alarm_t alarm_flags,
  output logic [15:0] meas_volt,
  output logic [15:0] meas_curr,
  output ops_pkg::ops_alarm_t alarm_seen
);
  import ops_pkg::*;
  // An external source holds the terminal even with the stage off.
  assign meas_volt = ext_on ? ext_volt : (dc_enable ? set_volt : 16'h0000);
  // Current flows only while the stage runs.
  assign meas_curr = dc_enable ? set_curr : 16'h0000;
  // The controller ignores alarm outputs until boot has finished.
  assign alarm_seen = ready ? alarm_flags : 7'h00;
endmodule

// ===== tb/ops_supervisor_tb.sv
// Self-checking bench for the supervisor, driving APB and plant levels.
// Assumes the design files and the plant model are compiled first.
`timescale 1ns/1ns
`include "ops_consts.svh"
module ops_supervisor_tb;
  import ops_pkg::*;
  localparam logic [5:0] E0 = 6'h10; // Mains good, no fault cause.
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [5:0] env; // Ext on, heat, wired, short, mains good, switch off.
  logic [15:0] ext_volt, set_volt, set_curr, meas_volt, meas_curr;
  logic [1:0] rmt; // Release and takeover requests.
  logic dc_enable, menu_access, ready, remote_active;
  logic nv_store, nv_store_on, shutdown_done;
  ops_alarm_t alarm_flags, alarm_seen;
  logic [11:0] obs; // Same layout as the status word.
  int fail_count, checks_done;
  assign obs = {remote_active, ready, menu_access, dc_enable, 1'b0, alarm_flags};
  // Short shutdown count keeps the run brief.
  ops_supervisor #(.SHUTDOWN_CYC(33'd20)) dut (.clk(clk), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_volt(meas_volt), .meas_curr(meas_curr),
    .overheat(env[1]), .share_bus_wired(env[2]), .share_bus_short(env[3]),
    .mains_ok(env[4]), .power_switch_off(env[5]), .remote_takeover(rmt[0]),
    .remote_release(rmt[1]), .nv_saved_on(1'b1), .dc_enable(dc_enable),
    .alarm_flags(alarm_flags), .menu_access(menu_access), .ready(ready),
    .remote_active(remote_active), .nv_store(nv_store), .nv_store_on(nv_store_on),
    .shutdown_done(shutdown_done));
  ops_plant plant (.dc_enable(dc_enable), .ext_on(env[0]), .ext_volt(ext_volt),
    .set_volt(set_volt), .set_curr(set_curr), .ready(ready), .alarm_flags(alarm_flags),
    .meas_volt(meas_volt), .meas_curr(meas_curr), .alarm_seen(alarm_seen));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Prints the verdict and stops the run.
  task tally_and_finish;
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compares one value and counts the outcome.
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, s, e);
    end
  endtask
  // Waits n edges, then lets that edge's updates settle.
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Compares the observed status bits after n edges.
  task look(input int n, input logic [11:0] e);
    tick(n);
    chk(32'(obs), 32'(e));
  endtask
  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Reads a register and compares it.
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  // Sets plant levels at one edge.
  task put(input logic [5:0] e, input logic [15:0] xv, sv, sc);
    @(posedge clk);
    env <= e;
    ext_volt <= xv;
    set_volt <= sv;
    set_curr <= sc;
  endtask
  // One-cycle remote request.
  task rpulse(input logic [1:0] v);
    @(posedge clk);
    rmt <= v;
    @(posedge clk);
    rmt <= 2'b00;
    tick(1);
  endtask
  // Bounded wait for ready (0) or shutdown_done (1).
  task automatic wait_bit(input int i, input int lim);
    int n;
    n = 0;
    while ((i == 0 ? ready : shutdown_done) !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      tally_and_finish;
    end
  endtask
  task do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // Main sequence.
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    env = E0;
    {ext_volt, set_volt, set_curr, rmt} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    look(1, 12'h200);
    rdc(`OPS_ADDR_OCTHR, 32'h0000ffff);
    rdc(`OPS_ADDR_OPTHR, 32'hffffffff);
    wr(`OPS_ADDR_OVTHR, 32'h0000ffff);
    rdc(`OPS_ADDR_OVTHR, 32'h000019c8);
    wr(`OPS_ADDR_CTRL, 32'h05);
    rdc(`OPS_ADDR_CTRL, 32'h04);
    wait_bit(0, 3000);
    look(2, 12'h500);
    wr(`OPS_ADDR_OVTHR, 32'd1000);
    put(E0 | 6'h01, 16'd1000, 0, 0);
    look(3, 12'h500);
    put(E0 | 6'h01, 16'd1001, 0, 0);
    look(3, 12'h602);
    chk(32'(alarm_seen), 32'h02);
    wr(`OPS_ADDR_ACK, 32'h02);
    look(2, 12'h602);
    put(E0, 0, 0, 0);
    look(3, 12'h602);
    wr(`OPS_ADDR_ACK, 32'h02);
    look(2, 12'h600);
    wr(`OPS_ADDR_CTRL, 32'h05);
    wr(`OPS_ADDR_OCTHR, 32'd500);
    put(E0, 0, 0, 16'd499);
    look(3, 12'h500);
    put(E0, 0, 0, 16'd500);
    look(3, 12'h604);
    put(E0, 0, 0, 0);
    wr(`OPS_ADDR_ACK, 32'h04);
    look(2, 12'h600);
    wr(`OPS_ADDR_CTRL, 32'h05);
    wr(`OPS_ADDR_OPTHR, 32'd10000);
    put(E0, 0, 16'd100, 16'd99);
    look(3, 12'h500);
    put(E0, 0, 16'd100, 16'd100);
    look(3, 12'h608);
    put(E0, 0, 0, 0);
    wr(`OPS_ADDR_ACK, 32'h08);
    wr(`OPS_ADDR_CTRL, 32'h07);
    look(2, 12'h500);
    put(E0 | 6'h02, 0, 0, 0);
    look(2, 12'h601);
    put(E0, 0, 0, 0);
    look(2, 12'h501);
    wr(`OPS_ADDR_ACK, 32'h01);
    look(2, 12'h500);
    wr(`OPS_ADDR_CTRL, 32'h05);
    put(E0 | 6'h02, 0, 0, 0);
    put(E0, 0, 0, 0);
    look(2, 12'h601);
    wr(`OPS_ADDR_ACK, 32'h01);
    wr(`OPS_ADDR_CTRL, 32'h05);
    put(E0 | 6'h04, 0, 0, 0);
    look(2, 12'h620);
    wr(`OPS_ADDR_ACK, 32'h20);
    look(2, 12'h620);
    put(E0, 0, 0, 0);
    wr(`OPS_ADDR_ACK, 32'h20);
    wr(`OPS_ADDR_CTRL, 32'h25);
    put(E0 | 6'h04, 0, 0, 0);
    look(2, 12'h500);
    put(E0 | 6'h08, 0, 0, 0);
    look(2, 12'h620);
    put(E0, 0, 0, 0);
    wr(`OPS_ADDR_ACK, 32'h20);
    rdc(`OPS_ADDR_COUNT, 32'd7);
    rdc(`OPS_ADDR_STATUS, 32'h600);
    rdc(`OPS_ADDR_ACK, 32'h0);
    rpulse(2'b01);
    chk(32'(obs), 32'he00);
    rpulse(2'b10);
    wr(`OPS_ADDR_CTRL, 32'h10);
    rpulse(2'b01);
    chk(32'(obs), 32'h600);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rdata[30:0], err}, 32'h1);
    wr(`OPS_ADDR_CTRL, 32'h01);
    put(6'h00, 0, 0, 0);
    look(2, 12'h640);
    put(E0, 0, 0, 0);
    look(2, 12'h640);
    wr(`OPS_ADDR_ACK, 32'h40);
    wr(`OPS_ADDR_CTRL, 32'h01);
    look(2, 12'h500);
    wr(`OPS_ADDR_CTRL, 32'h09);
    put(6'h00, 0, 0, 0);
    look(2, 12'h640);
    put(E0, 0, 0, 0);
    look(2, 12'h540);
    wr(`OPS_ADDR_ACK, 32'h40);
    put(E0 | 6'h20, 0, 0, 0);
    tick(1);
    chk(32'({nv_store, nv_store_on}), 32'h3);
    look(1, 12'h240);
    chk(32'({nv_store, shutdown_done}), 32'h0);
    wait_bit(1, 40);
    put(E0, 0, 0, 0);
    do_reset;
    put(E0 | 6'h01, 16'd6059, 0, 0);
    look(3, 12'h200);
    put(E0 | 6'h01, 16'd6060, 0, 0);
    look(3, 12'h210);
    chk(32'(alarm_seen), 32'h0);
    put(E0, 0, 0, 0);
    wr(`OPS_ADDR_ACK, 32'h10);
    look(2, 12'h210);
    do_reset;
    look(1, 12'h200);
    tally_and_finish;
  end
endmodule
